// ---- iopci_pkg.sv ----
// Shared constants, opcodes and carrier types of the port, change-detect,
// interrupt gating and tone output block.
// Assumes the core issues one decoded instruction per cycle as a command.
package iopci_pkg;

    localparam int PORT_W = 4;
    localparam int EVT_W = 8;
    localparam int VEC_W = 11;
    localparam int TONE_CNT_W = 15;

    // Port structure control field positions.
    localparam int PSC_OD_A = 0;
    localparam int PSC_OD_B = 1;
    localparam int PSC_PU_WAKE = 2;
    localparam int PSC_PU_PLAIN = 3;
    localparam logic [3:0] PSC_RESET = 4'h0;
    localparam logic [3:0] DIR_RESET = 4'hF;
    localparam logic [3:0] LED_RESET = 4'hF;
    localparam int T1M_TONE_SEL = 2;

    // Event flag and interrupt enable mask bit positions.
    localparam int EV_DIV0 = 0;
    localparam int EV_TMR0 = 1;
    localparam int EV_CHG = 2;
    localparam int EV_ALT4 = 4;
    localparam int EV_TMR1 = 7;
    localparam logic [7:0] EV_VALID = 8'h97;
    localparam logic [7:0] EV_CHG_MASK = 8'h04;

    // Vector of enable bit n is VEC_BASE + n * 4, giving 004H to 020H.
    localparam logic [10:0] VEC_BASE = 11'h004;
    localparam logic [10:0] VEC_LAST = 11'h020;
    localparam int VEC_SHIFT = 2;

    // Pattern operand fields and tone divider taps for a 32768 Hz tick.
    localparam int PAT_CAR_HI = 7;
    localparam int PAT_CAR_LO = 6;
    localparam int PAT_MOD_W = 6;
    localparam logic [1:0] CAR_LOW = 2'h0;
    localparam logic [1:0] CAR_HIGH = 2'h1;
    localparam logic [1:0] CAR_2048 = 2'h2;
    localparam int TAP_4096 = 2;
    localparam int TAP_2048 = 3;
    localparam int TAP_128 = 7;
    localparam int TAP_64 = 8;
    localparam int TAP_8 = 11;
    localparam int TAP_4 = 12;
    localparam int TAP_2 = 13;
    localparam int TAP_1 = 14;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00, OP_WR_PSC = 5'h01, OP_WR_DIR_A = 5'h02,
        OP_WR_DIR_B = 5'h03, OP_WR_CHG_EN = 5'h04, OP_WR_HOLD_EN = 5'h05,
        OP_WR_STOP_WAKE = 5'h06, OP_WR_PATTERN = 5'h07,
        OP_WR_IRQ_MASK = 5'h08, OP_WR_T1MODE = 5'h09, OP_WR_PORT_A = 5'h0A,
        OP_WR_PORT_B = 5'h0B, OP_WR_LED = 5'h0C, OP_CHANGE_CLEAR = 5'h0D,
        OP_EVF_CLEAR = 5'h0E, OP_IRQ_ENABLE = 5'h0F, OP_IRQ_MASK = 5'h10,
        OP_RETURN = 5'h11, OP_HOLD = 5'h12, OP_STOP = 5'h13
    } iopci_op_t;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1, ST_HOLD = 4'h2, ST_STOP = 4'h4, ST_HOLD_ISR = 4'h8
    } iopci_state_t;

    typedef struct packed {
        logic valid;
        iopci_op_t op;
        logic [7:0] imm;
    } iopci_cmd_t;

    typedef struct packed {
        logic div0Ovf;
        logic tmr0Udf;
        logic alt4Event;
        logic tmr1Udf;
    } iopci_evt_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } iopci_pin_t;

endpackage

// ---- iopci_ports.sv ----
// Port modes, change detection, interrupt gating, hold/stop interplay and
// tone pattern output of a small 4-bit controller.
// Assumes commands, events and pins are synchronous to clk, except the
// wake inputs, which are synchronised here; fwTick pulses at 32768 Hz.
`timescale 1ns/10ps
`default_nettype none

module iopci_ports
(
    input wire logic clk,
    input wire logic rst,
    input wire iopci_pkg::iopci_cmd_t cmd,
    input wire iopci_pkg::iopci_evt_t evt,
    input wire logic fwTick,
    input wire logic tmr1Tone,
    input wire logic [3:0] portAIn,
    input wire logic [3:0] portBIn,
    input wire logic [3:0] wakeIn,
    input wire logic [3:0] plainIn,
    output iopci_pkg::iopci_pin_t portADrv,
    output iopci_pkg::iopci_pin_t portBDrv,
    output logic pullUpWakeEn,
    output logic pullUpPlainEn,
    output logic [3:0] ledSink,
    output logic toneOut,
    output logic [3:0] changeStatus,
    output logic [7:0] eventFlags,
    output logic [3:0] portARead,
    output logic [3:0] portBRead,
    output logic [3:0] plainRead,
    output logic irqTake,
    output logic [10:0] irqVector,
    output logic inHold,
    output logic inStop
);
    import iopci_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Mode registers.
    logic [3:0] psc_ff;
    logic [3:0] dirA_ff;
    logic [3:0] dirB_ff;
    logic [3:0] dataA_ff;
    logic [3:0] dataB_ff;
    logic [3:0] chgEn_ff;
    logic [3:0] stopWake_ff;
    logic [7:0] holdEn_ff;
    logic [7:0] irqMask_ff;
    logic [7:0] pattern_ff;
    logic toneSelT1_ff;
    logic [3:0] led_ff;
    logic wr;

    assign wr = cmd.valid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            psc_ff <= PSC_RESET;
            dirA_ff <= DIR_RESET;
            dirB_ff <= DIR_RESET;
        end
        else if (wr && cmd.op == OP_WR_PSC)
        begin
            psc_ff <= cmd.imm[3:0];
        end
        else if (wr && cmd.op == OP_WR_DIR_A)
        begin
            dirA_ff <= cmd.imm[3:0];
        end
        else if (wr && cmd.op == OP_WR_DIR_B)
        begin
            dirB_ff <= cmd.imm[3:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chgEn_ff <= 4'h0;
            stopWake_ff <= 4'h0;
            holdEn_ff <= 8'h00;
            irqMask_ff <= 8'h00;
        end
        else if (wr)
        begin
            case (cmd.op)
                OP_WR_CHG_EN: chgEn_ff <= cmd.imm[3:0];
                OP_WR_STOP_WAKE: stopWake_ff <= cmd.imm[3:0];
                OP_WR_HOLD_EN: holdEn_ff <= cmd.imm & EV_VALID;
                OP_WR_IRQ_MASK: irqMask_ff <= cmd.imm & EV_VALID;
                default: chgEn_ff <= chgEn_ff;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pattern_ff <= 8'h00;
            toneSelT1_ff <= 1'b0;
            dataA_ff <= 4'h0;
            dataB_ff <= 4'h0;
            led_ff <= LED_RESET;
        end
        else if (wr)
        begin
            case (cmd.op)
                OP_WR_PATTERN: pattern_ff <= cmd.imm;
                OP_WR_T1MODE: toneSelT1_ff <= cmd.imm[T1M_TONE_SEL];
                OP_WR_PORT_A: dataA_ff <= cmd.imm[3:0];
                OP_WR_PORT_B: dataB_ff <= cmd.imm[3:0];
                OP_WR_LED: led_ff <= cmd.imm[3:0];
                default: led_ff <= led_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive and input sampling.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            portADrv <= '0;
            portBDrv <= '0;
            pullUpWakeEn <= 1'b0;
            pullUpPlainEn <= 1'b0;
            ledSink <= LED_RESET;
            portARead <= 4'h0;
            portBRead <= 4'h0;
            plainRead <= 4'h0;
        end
        else
        begin
            portADrv.oe <= ~dirA_ff & (psc_ff[PSC_OD_A] ? ~dataA_ff : 4'hF);
            portADrv.out <= psc_ff[PSC_OD_A] ? 4'h0 : dataA_ff;
            portBDrv.oe <= ~dirB_ff & (psc_ff[PSC_OD_B] ? ~dataB_ff : 4'hF);
            portBDrv.out <= psc_ff[PSC_OD_B] ? 4'h0 : dataB_ff;
            pullUpWakeEn <= psc_ff[PSC_PU_WAKE];
            pullUpPlainEn <= psc_ff[PSC_PU_PLAIN];
            ledSink <= led_ff;
            portARead <= portAIn;
            portBRead <= portBIn;
            plainRead <= plainIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake port synchroniser and change detection.
    logic [3:0] wakeS1_ff;
    logic [3:0] wakeS2_ff;
    logic [3:0] wakeS3_ff;
    logic [3:0] wakeChg;
    logic [3:0] wakeFall;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wakeS1_ff <= 4'h0;
            wakeS2_ff <= 4'h0;
            wakeS3_ff <= 4'h0;
        end
        else
        begin
            wakeS1_ff <= wakeIn;
            wakeS2_ff <= wakeS1_ff;
            wakeS3_ff <= wakeS2_ff;
        end
    end

    assign wakeChg = wakeS2_ff ^ wakeS3_ff;
    assign wakeFall = wakeS3_ff & ~wakeS2_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            changeStatus <= 4'h0;
        end
        else
        begin
            changeStatus <= (wr && cmd.op == OP_CHANGE_CLEAR ? 4'h0 :
                changeStatus) | wakeChg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags, priority and interrupt acceptance.
    iopci_state_t state_ff;
    logic irqGlobalEn_ff;
    logic [7:0] evtSet;
    logic [7:0] pending;
    logic [7:0] takeMask;
    logic [7:0] relMask;
    logic [2:0] takeIdx;
    logic takeNow;
    logic holdRelease;

    function automatic logic [2:0] lowestSet(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = EVT_W - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = i[2:0];
            end
        end
        return idx;
    endfunction

    always_comb
    begin
        evtSet = 8'h00;
        evtSet[EV_DIV0] = evt.div0Ovf;
        evtSet[EV_TMR0] = evt.tmr0Udf;
        evtSet[EV_CHG] = |(wakeChg & chgEn_ff);
        evtSet[EV_ALT4] = evt.alt4Event;
        evtSet[EV_TMR1] = evt.tmr1Udf;
    end

    assign pending = eventFlags & irqMask_ff & EV_VALID;
    assign takeIdx = lowestSet(pending);
    assign takeMask = 8'h01 << takeIdx;
    assign takeNow = irqGlobalEn_ff && (|pending) &&
        (state_ff == ST_RUN || state_ff == ST_HOLD);
    // Port change also needs mask bit
    assign relMask = holdEn_ff & (irqMask_ff | ~EV_CHG_MASK);
    assign holdRelease = |(eventFlags & relMask);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            eventFlags <= 8'h00;
        end
        else
        begin
            eventFlags <= (eventFlags
                & ~(wr && cmd.op == OP_EVF_CLEAR ? cmd.imm : 8'h00)
                & ~(takeNow ? takeMask : 8'h00)) | evtSet;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqGlobalEn_ff <= 1'b1;
        end
        else if (takeNow)
        begin
            irqGlobalEn_ff <= 1'b0;
        end
        else if (wr && (cmd.op == OP_IRQ_ENABLE || cmd.op == OP_WR_IRQ_MASK))
        begin
            irqGlobalEn_ff <= 1'b1;
        end
        else if (wr && cmd.op == OP_IRQ_MASK)
        begin
            irqGlobalEn_ff <= 1'b0;
        end
    end

    // Vector from 004H in steps of four
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqTake <= 1'b0;
            irqVector <= VEC_BASE;
        end
        else
        begin
            irqTake <= takeNow;
            if (takeNow)
            begin
                irqVector <= VEC_BASE + (11'(takeIdx) << VEC_SHIFT);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold and stop mode sequencing.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ST_RUN;
        end
        else
        begin
            case (state_ff)
                ST_RUN:
                begin
                    if (wr && cmd.op == OP_STOP)
                    begin
                        state_ff <= ST_STOP;
                    end
                    else if (wr && cmd.op == OP_HOLD && !holdRelease)
                    begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (takeNow)
                    begin
                        state_ff <= ST_HOLD_ISR;
                    end
                    else if (holdRelease)
                    begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_STOP:
                begin
                    if (|(wakeFall & stopWake_ff))
                    begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_HOLD_ISR:
                begin
                    if (wr && cmd.op == OP_RETURN)
                    begin
                        state_ff <= ST_HOLD;
                    end
                end
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    assign inHold = state_ff[1];
    assign inStop = state_ff[2];

    ////////////////////////////////////////////////////////////////////////
    // Tone pattern generator.
    logic [TONE_CNT_W-1:0] toneCnt_ff;
    logic [PAT_MOD_W-1:0] modTaps;
    logic [1:0] carSel;
    logic carrier;
    logic patOut;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            toneCnt_ff <= '0;
        end
        else if (fwTick)
        begin
            toneCnt_ff <= toneCnt_ff + 1'b1;
        end
    end

    assign carSel = pattern_ff[PAT_CAR_HI:PAT_CAR_LO];
    always_comb
    begin
        case (carSel)
            CAR_LOW: carrier = 1'b0;
            CAR_HIGH: carrier = 1'b1;
            CAR_2048: carrier = toneCnt_ff[TAP_2048];
            default: carrier = toneCnt_ff[TAP_4096];
        endcase
    end

    assign modTaps = {toneCnt_ff[TAP_1], toneCnt_ff[TAP_2],
        toneCnt_ff[TAP_4], toneCnt_ff[TAP_8], toneCnt_ff[TAP_64],
        toneCnt_ff[TAP_128]};
    assign patOut = (pattern_ff[PAT_MOD_W-1:0] == '0) ? carrier :
        carrier & |(modTaps & pattern_ff[PAT_MOD_W-1:0]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            toneOut <= 1'b0;
        end
        else
        begin
            toneOut <= toneSelT1_ff ? tmr1Tone : patOut;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take;
        takeNow;
    endsequence
    sequence s_noReenable;
        !(wr && (cmd.op == OP_IRQ_ENABLE || cmd.op == OP_WR_IRQ_MASK));
    endsequence

    property p_resetDir;
        $past(rst) |-> portADrv.oe == 4'h0 && portBDrv.oe == 4'h0;
    endproperty
    a_resetDir: assert property (p_resetDir)
        else $error("ports not inputs after reset");

    property p_openDrain;
        psc_ff[PSC_OD_A] |=> portADrv.out == 4'h0;
    endproperty
    a_openDrain: assert property (p_openDrain)
        else $error("open-drain port drove high");

    property p_changeSet;
        |wakeChg |=> (changeStatus & $past(wakeChg)) == $past(wakeChg);
    endproperty
    a_changeSet: assert property (p_changeSet)
        else $error("change not recorded");

    property p_onlyTakenCleared;
        takeNow && !(wr && cmd.op == OP_EVF_CLEAR) |=>
            (eventFlags & ~$past(takeMask)) ==
            (($past(eventFlags) | $past(evtSet)) & ~$past(takeMask));
    endproperty
    a_onlyTakenCleared: assert property (p_onlyTakenCleared)
        else $error("other event flags disturbed");

    property p_inhibit;
        s_take ##1 s_noReenable ##1 s_noReenable |-> !takeNow;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("interrupt taken while inhibited");

    property p_vecRange;
        irqTake |-> irqVector >= VEC_BASE && irqVector <= VEC_LAST &&
            irqVector[1:0] == 2'h0;
    endproperty
    a_vecRange: assert property (p_vecRange)
        else $error("vector out of range");

    property p_stopWake;
        inStop && |(wakeFall & stopWake_ff) |=> !inStop;
    endproperty
    a_stopWake: assert property (p_stopWake)
        else $error("stop not left on falling edge");

    property p_holdReturn;
        state_ff == ST_HOLD_ISR && wr && cmd.op == OP_RETURN |=> inHold;
    endproperty
    a_holdReturn: assert property (p_holdReturn)
        else $error("hold not re-entered after return");

    property p_toneLow;
        !toneSelT1_ff && pattern_ff == 8'h00 |=> !toneOut;
    endproperty
    a_toneLow: assert property (p_toneLow)
        else $error("low carrier not low");

    property p_toneT1;
        toneSelT1_ff |=> toneOut == $past(tmr1Tone);
    endproperty
    a_toneT1: assert property (p_toneT1)
        else $error("timer 1 tone not routed");

endmodule
`default_nettype wire

// ---- iopci_board.sv ----
// Board model: switches on the input ports and wiring of the port pins.
// Assumes the bench sets switch positions and external pin levels.
`timescale 1ns/10ps
`default_nettype none
module iopci_board
(
    input wire logic clk,
    input wire iopci_pkg::iopci_pin_t portADrv,
    input wire iopci_pkg::iopci_pin_t portBDrv,
    input wire logic pullUpWakeEn,
    input wire logic pullUpPlainEn,
    input wire logic [3:0] extA,
    input wire logic [3:0] extB,
    input wire logic [3:0] wakeClosed,
    input wire logic [3:0] plainClosed,
    output logic [3:0] portAIn,
    output logic [3:0] portBIn,
    output logic [3:0] wakeIn,
    output logic [3:0] plainIn
);
    import iopci_pkg::*;
    logic flip = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // An open switch without pull-up floats, so it shows a changing level.
    always @(posedge clk)
        flip <= ~flip;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wakeIn[i] = wakeClosed[i] ? 1'b0 : (pullUpWakeEn | flip);
            plainIn[i] = plainClosed[i] ? 1'b0 : (pullUpPlainEn | flip);
            portAIn[i] = portADrv.oe[i] ? portADrv.out[i] : extA[i];
            portBIn[i] = portBDrv.oe[i] ? portBDrv.out[i] : extB[i];
        end
    end
endmodule
`default_nettype wire

// ---- iopci_ports_tb_top.sv ----
// Self-checking bench of the port, change, interrupt and tone block.
// Assumes the board model stands at the pins; commands come from here.
`timescale 1ns/10ps
`default_nettype none
module iopci_ports_tb_top;
    import iopci_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    iopci_cmd_t cmd = '0;
    iopci_evt_t evt = '0;
    logic tmr1Tone = 1'b0;
    logic [3:0] extA = 4'h0;
    logic [3:0] extB = 4'hF;
    logic [3:0] wakeClosed = 4'h0;
    logic [3:0] plainClosed = 4'h0;
    logic [3:0] portAIn, portBIn, wakeIn, plainIn, ledSink, changeStatus;
    logic [3:0] portARead, portBRead, plainRead;
    iopci_pin_t portADrv, portBDrv;
    logic pullUpWakeEn, pullUpPlainEn, toneOut, irqTake, inHold, inStop;
    logic [7:0] eventFlags;
    logic [10:0] irqVector;
    int errors = 0;
    int comparisons = 0;
    always #12.5 clk = ~clk;
    iopci_ports dut
    (
        .clk(clk), .rst(rst), .cmd(cmd), .evt(evt), .fwTick(1'b1),
        .tmr1Tone(tmr1Tone), .portAIn(portAIn), .portBIn(portBIn),
        .wakeIn(wakeIn), .plainIn(plainIn), .portADrv(portADrv),
        .portBDrv(portBDrv), .pullUpWakeEn(pullUpWakeEn),
        .pullUpPlainEn(pullUpPlainEn), .ledSink(ledSink),
        .toneOut(toneOut), .changeStatus(changeStatus),
        .eventFlags(eventFlags), .portARead(portARead),
        .portBRead(portBRead), .plainRead(plainRead), .irqTake(irqTake),
        .irqVector(irqVector), .inHold(inHold), .inStop(inStop)
    );
    iopci_board board
    (
        .clk(clk), .portADrv(portADrv), .portBDrv(portBDrv),
        .pullUpWakeEn(pullUpWakeEn), .pullUpPlainEn(pullUpPlainEn),
        .extA(extA), .extB(extB), .wakeClosed(wakeClosed),
        .plainClosed(plainClosed), .portAIn(portAIn), .portBIn(portBIn),
        .wakeIn(wakeIn), .plainIn(plainIn)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] got, input logic [10:0] exp,
                       input string m);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic op(input iopci_op_t o, input logic [7:0] imm);
        @(negedge clk);
        cmd = '{1'b1, o, imm};
        @(negedge clk);
        cmd = '0;
    endtask
    task automatic pulse(input iopci_evt_t e);
        @(negedge clk);
        evt = e;
        @(negedge clk);
        evt = '0;
    endtask
    // Waits a bounded time for an accepted interrupt, or for none.
    task automatic take(input logic [10:0] vec, input logic hit,
                        input string m);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 12 && !seen; i++)
        begin
            @(negedge clk);
            if (irqTake === 1'b1)
            begin
                seen = 1'b1;
                chk(irqVector, vec, m);
            end
        end
        chk(11'(seen), 11'(hit), m);
    endtask
    task automatic tone_case(input logic [7:0] pat, input int hi,
                             input int ch);
        int h;
        int c;
        logic prev;
        op(OP_WR_PATTERN, pat);
        idle(3);
        h = 0;
        c = 0;
        prev = toneOut;
        repeat (512)
        begin
            @(negedge clk);
            h += (toneOut === 1'b1);
            c += (toneOut !== prev);
            prev = toneOut;
        end
        chk(11'(h), 11'(hi), "tone level");
        chk(11'(c), 11'(ch), "tone edges");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        idle(5);
        chk(11'({portADrv.oe, portBDrv.oe}), 11'h000, "oe");
        chk(11'({pullUpWakeEn, pullUpPlainEn}), 11'h000, "pu");
        chk(11'(ledSink), 11'h00F, "led");
        chk(11'({changeStatus, eventFlags}), 11'h000, "flags");
        chk(irqVector, 11'h004, "vector");
        rst = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_dir();
        op(OP_WR_PORT_A, 8'h0A);
        op(OP_WR_PORT_B, 8'h0A);
        idle(2);
        chk(11'({portADrv.oe, portBDrv.oe}), 11'h000, "input");
        op(OP_WR_DIR_A, 8'h03);
        op(OP_WR_DIR_B, 8'h00);
        idle(2);
        chk(11'(portADrv.oe), 11'h00C, "dir a");
        chk(11'(portBDrv.oe), 11'h00F, "dir b");
        chk(11'(portARead), 11'h008, "read a");
        chk(11'(portBRead), 11'h00A, "read b");
        op(OP_WR_PSC, 8'h03);
        idle(2);
        chk(11'(portADrv.oe), 11'h004, "od a");
        chk(11'(portBDrv.oe), 11'h005, "od b");
        $display("test dir done");
    endtask
    task automatic t_led();
        for (int v = 5; v < 16; v += 5)
        begin
            op(OP_WR_LED, 8'(v));
            idle(2);
            chk(11'(ledSink), 11'(v), "led");
        end
        $display("test led done");
    endtask
    task automatic t_change();
        op(OP_WR_PSC, 8'h0C);
        idle(4);
        chk(11'({pullUpWakeEn, pullUpPlainEn}), 11'h003, "pu");
        chk(11'(plainRead), 11'h00F, "plain pu");
        op(OP_CHANGE_CLEAR, 8'h00);
        idle(2);
        chk(11'(changeStatus), 11'h000, "clear");
        op(OP_WR_CHG_EN, 8'h02);
        op(OP_WR_IRQ_MASK, 8'h04);
        plainClosed = 4'hF;
        take(11'h000, 1'b0, "plain");
        chk(11'(changeStatus), 11'h000, "plain");
        chk(11'(plainRead), 11'h000, "plain read");
        wakeClosed = 4'h1;
        take(11'h000, 1'b0, "off pin");
        chk(11'({changeStatus, eventFlags}), 11'h100, "pin 0");
        wakeClosed = 4'h3;
        take(11'h00C, 1'b1, "pin 1");
        chk(11'(changeStatus), 11'h003, "pin 1");
        op(OP_IRQ_ENABLE, 8'h00);
        wakeClosed = 4'h0;
        take(11'h00C, 1'b1, "rise");
        op(OP_CHANGE_CLEAR, 8'h00);
        op(OP_WR_CHG_EN, 8'h00);
        idle(2);
        chk(11'(changeStatus), 11'h000, "clear");
        $display("test change done");
    endtask
    task automatic t_irq();
        op(OP_WR_IRQ_MASK, 8'h02);
        pulse(4'b0100);
        take(11'h008, 1'b1, "timer 0");
        chk(11'(eventFlags), 11'h000, "acked");
        pulse(4'b0100);
        take(11'h000, 1'b0, "inhibit");
        chk(11'(eventFlags), 11'h002, "pending");
        op(OP_IRQ_ENABLE, 8'h00);
        take(11'h008, 1'b1, "enable");
        op(OP_IRQ_ENABLE, 8'h00);
        op(OP_IRQ_MASK, 8'h00);
        pulse(4'b0100);
        take(11'h000, 1'b0, "disable");
        op(OP_EVF_CLEAR, 8'hFF);
        op(OP_IRQ_ENABLE, 8'h00);
        op(OP_WR_IRQ_MASK, 8'h99);
        pulse(4'b1111);
        take(11'h004, 1'b1, "first");
        op(OP_IRQ_ENABLE, 8'h00);
        take(11'h014, 1'b1, "second");
        op(OP_IRQ_ENABLE, 8'h00);
        take(11'h020, 1'b1, "last");
        chk(11'(eventFlags), 11'h002, "masked");
        op(OP_EVF_CLEAR, 8'hFF);
        $display("test irq done");
    endtask
    task automatic t_tone();
        op(OP_WR_T1MODE, 8'h04);
        tmr1Tone = 1'b1;
        idle(3);
        chk(11'(toneOut), 11'h001, "timer tone");
        tmr1Tone = 1'b0;
        idle(3);
        chk(11'(toneOut), 11'h000, "timer tone");
        op(OP_WR_T1MODE, 8'h00);
        tmr1Tone = 1'b1;
        tone_case(8'h00, 0, 0);
        tone_case(8'h40, 512, 0);
        tone_case(8'h80, 256, 64);
        tone_case(8'hC0, 256, 128);
        tone_case(8'hC1, 128, 64);
        tone_case(8'h81, 128, 32);
        tone_case(8'h43, 384, 2);
        $display("test tone done");
    endtask
    task automatic t_stop();
        op(OP_WR_STOP_WAKE, 8'h01);
        op(OP_STOP, 8'h00);
        idle(2);
        chk(11'(inStop), 11'h001, "stop");
        wakeClosed = 4'h2;
        idle(6);
        chk(11'(inStop), 11'h001, "other pin");
        wakeClosed = 4'h3;
        idle(6);
        chk(11'(inStop), 11'h000, "wake");
        $display("test stop done");
    endtask
    task automatic t_hold();
        op(OP_WR_HOLD_EN, 8'h02);
        op(OP_WR_IRQ_MASK, 8'h02);
        op(OP_HOLD, 8'h00);
        idle(2);
        chk(11'(inHold), 11'h001, "hold");
        pulse(4'b0100);
        take(11'h008, 1'b1, "hold irq");
        op(OP_RETURN, 8'h00);
        idle(2);
        chk(11'(inHold), 11'h001, "rehold");
        $display("test hold done");
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #500000;
        errors++;
        close_out();
    end
    initial
    begin
        t_reset();
        t_dir();
        t_led();
        t_change();
        t_irq();
        t_tone();
        t_stop();
        t_hold();
        close_out();
    end
endmodule
`default_nettype wire
